// ### include/sio_pkg.sv
// Constants and types shared by the servo I/O and probe object block.
// Assumes one 40 MHz clock and object access by 16-bit index plus subindex.
package sio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Object indices and subindices
  localparam logic [15:0] IDX_PROBE_CTRL = 16'h60B8;
  localparam logic [15:0] IDX_PROBE_STAT = 16'h60B9;
  localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
  localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
  localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
  localparam logic [15:0] IDX_P2_FALL = 16'h60BD;
  localparam logic [15:0] IDX_POS_TQ = 16'h60E0;
  localparam logic [15:0] IDX_NEG_TQ = 16'h60E1;
  localparam logic [15:0] IDX_DIG_IN = 16'h60FD;
  localparam logic [15:0] IDX_HOST_OUT = 16'h60FE;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_HOST_VAL = 8'h01;
  localparam logic [7:0] SUB_HOST_MASK = 8'h02;
  localparam logic [31:0] HOST_OUT_COUNT = 32'h00000002;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and ranges
  localparam logic [15:0] TQ_LIMIT_RESET = 16'h0BB8;
  localparam logic [15:0] TQ_LIMIT_MAX = 16'h0BB8;
  localparam logic [15:0] PROBE_CTRL_RESET = 16'h0000;
  localparam logic [31:0] HOST_OUT_RESET = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int HOST_IN_LSB = 28;
  localparam int HOST_IN_COUNT = 3;
  localparam int DIG_NEG_LIM_BIT = 0;
  localparam int DIG_POS_LIM_BIT = 1;
  localparam int DIG_HOME_BIT = 2;
  localparam int DIG_CN1_LSB = 16;
  localparam int CN1_COUNT = 8;
  localparam int FN_WIDTH = 3;
  localparam int PC_ENABLE = 0;
  localparam int PC_CONT = 1;
  localparam int PC_SRC_INDEX = 2;
  localparam int PC_RISE = 4;
  localparam int PC_FALL = 5;
  localparam int PROBE_TWO_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Input function codes and homing methods
  localparam logic [2:0] FN_NONE = 3'h0;
  localparam logic [2:0] FN_NEG_LIMIT = 3'h1;
  localparam logic [2:0] FN_POS_LIMIT = 3'h2;
  localparam logic [2:0] FN_HOME = 3'h3;
  localparam logic [2:0] FN_PROBE_ONE = 3'h4;
  localparam logic [2:0] FN_PROBE_TWO = 3'h5;
  localparam logic [7:0] HM_NEG_STALL_INDEX = 8'hFD;
  localparam logic [7:0] HM_POS_STALL_HERE = 8'hFE;
  localparam logic [7:0] HM_NEG_STALL_HERE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SIO_HM_IDLE,
    SIO_HM_STALL,
    SIO_HM_INDEX,
    SIO_HM_SWITCH,
    SIO_HM_DONE
  } sio_hm_state_t;

endpackage

// ### rtl/sio_probe_channel.sv
// One touch-probe latch channel: trigger select, edge latch, status.
// Assumes trigger levels already synchronised to the block clock.
module sio_probe_channel (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] cfg_in,
  input wire logic ext_trig_in,
  input wire logic index_in,
  input wire logic [31:0] position_in,
  output logic [7:0] status_out,
  output logic [31:0] rise_pos_out,
  output logic [31:0] fall_pos_out
);

  typedef struct packed {
    logic trig_prev;
    logic en;
    logic rise_done;
    logic fall_done;
    logic [1:0] count;
    logic [31:0] rise_pos;
    logic [31:0] fall_pos;
  } sio_probe_state_t;

  sio_probe_state_t state_reg;
  sio_probe_state_t state_next;
  logic trig;
  logic rise_ok;
  logic fall_ok;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    trig = cfg_in[sio_pkg::PC_SRC_INDEX] ? index_in : ext_trig_in;
    rise_ok = 1'b0;
    fall_ok = 1'b0;
    state_next.trig_prev = trig;
    state_next.en = cfg_in[sio_pkg::PC_ENABLE];
    if (!cfg_in[sio_pkg::PC_ENABLE]) begin
      // Disabling re-arms single mode and clears the latch flags
      state_next.rise_done = 1'b0;
      state_next.fall_done = 1'b0;
      state_next.count = 2'h0;
    end else begin
      // Single mode takes only the first edge of each kind
      rise_ok = cfg_in[sio_pkg::PC_RISE] & trig & ~state_reg.trig_prev &
                (cfg_in[sio_pkg::PC_CONT] | ~state_reg.rise_done);
      fall_ok = cfg_in[sio_pkg::PC_FALL] & ~trig & state_reg.trig_prev &
                (cfg_in[sio_pkg::PC_CONT] | ~state_reg.fall_done);
      if (rise_ok) begin
        state_next.rise_pos = position_in;
        state_next.rise_done = 1'b1;
      end
      if (fall_ok) begin
        state_next.fall_pos = position_in;
        state_next.fall_done = 1'b1;
      end
      if (cfg_in[sio_pkg::PC_CONT] && (rise_ok || fall_ok)) begin
        state_next.count = state_reg.count + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status_out = {state_reg.count, 3'h0, state_reg.fall_done,
                       state_reg.rise_done, state_reg.en};
  assign rise_pos_out = state_reg.rise_pos;
  assign fall_pos_out = state_reg.fall_pos;

endmodule // sio_probe_channel

// ### rtl/sio_servo_io.sv
// Servo drive object set: hard-stop homing, torque limits, digital
// inputs with host override, and two touch-probe latch channels.
// Assumes object requests, position and torque come from same-clock logic;
// switch, connector, index and external inputs are asynchronous pins.
module sio_servo_io #(
  parameter int MS_CYCLES = sio_pkg::MS_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic obj_req_in,
  input wire logic obj_write_in,
  input wire logic [15:0] obj_index_in,
  input wire logic [7:0] obj_subindex_in,
  input wire logic [31:0] obj_wdata_in,
  output logic obj_ack_out,
  output logic obj_abort_out,
  output logic [31:0] obj_rdata_out,
  input wire logic [7:0] digital_input_connector_in,
  input wire logic neg_limit_pin_in,
  input wire logic pos_limit_pin_in,
  input wire logic home_switch_pin_in,
  input wire logic encoder_index_mark_in,
  input wire logic encoder_external_input_in,
  input wire logic [7:0] input_invert_param_in,
  input wire logic [23:0] input_function_param_in,
  input wire logic [7:0] homing_method_in,
  input wire logic homing_start_in,
  input wire logic homing_stop_in,
  input wire logic homing_pref_pos_in,
  input wire logic [15:0] stall_torque_threshold_param_in,
  input wire logic [15:0] blocking_time_param_in,
  input wire logic signed [15:0] torque_feedback_in,
  input wire logic signed [15:0] torque_cmd_in,
  input wire logic signed [31:0] feedback_position_in,
  output logic drive_pos_out,
  output logic drive_neg_out,
  output logic homing_done_out,
  output logic [31:0] home_position_out,
  output logic signed [15:0] torque_cmd_out,
  output logic [15:0] pos_torque_limit_out,
  output logic [15:0] neg_torque_limit_out
);

  localparam int PIN_W = 13;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic index_prev;
    sio_pkg::sio_hm_state_t hm;
    logic [15:0] ms_cnt;
    logic [15:0] blk_cnt;
    logic hm_is_index;
    logic dir_pos;
    logic dir_neg;
    logic done;
    logic [31:0] home_pos;
    logic [15:0] probe_ctrl;
    logic [15:0] pos_lim;
    logic [15:0] neg_lim;
    logic [31:0] host_val;
    logic [31:0] host_mask;
    logic signed [15:0] torque_cmd;
    logic ack;
    logic abort;
    logic [31:0] rdata;
  } sio_main_state_t;

  sio_main_state_t state_reg;
  sio_main_state_t state_next;

  logic [7:0] cn1_eff;
  logic sw_neg;
  logic sw_pos;
  logic sw_home;
  logic probe_one;
  logic probe_two;
  logic index_lvl;
  logic ext_lvl;
  logic index_rise;
  logic [2:0] fn;
  logic [31:0] dig_in;
  logic [16:0] tq_abs;
  logic stalled;
  logic ms_tick;
  logic signed [16:0] cmd_ext;
  logic signed [16:0] pos_cap;
  logic signed [16:0] neg_cap;
  logic [15:0] probe_status;
  logic [31:0] p1_rise;
  logic [31:0] p1_fall;
  logic [31:0] p2_rise;
  logic [31:0] p2_fall;
  logic wr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Probe channels
  sio_probe_channel u_probe_one (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .cfg_in(state_reg.probe_ctrl[7:0]),
    .ext_trig_in(probe_one | ext_lvl),
    .index_in(index_lvl),
    .position_in(feedback_position_in),
    .status_out(probe_status[7:0]),
    .rise_pos_out(p1_rise),
    .fall_pos_out(p1_fall)
  );

  sio_probe_channel u_probe_two (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .cfg_in(state_reg.probe_ctrl[15:8]),
    .ext_trig_in(probe_two),
    .index_in(index_lvl),
    .position_in(feedback_position_in),
    .status_out(probe_status[15:8]),
    .rise_pos_out(p2_rise),
    .fall_pos_out(p2_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning; only the second sync stage is read here
  always_comb begin
    index_lvl = state_reg.sync2[8];
    ext_lvl = state_reg.sync2[12];
    index_rise = index_lvl & ~state_reg.index_prev;
    sw_neg = state_reg.sync2[9];
    sw_pos = state_reg.sync2[10];
    sw_home = state_reg.sync2[11];
    probe_one = 1'b0;
    probe_two = 1'b0;
    fn = sio_pkg::FN_NONE;
    for (int i = 0; i < sio_pkg::CN1_COUNT; i++) begin
      cn1_eff[i] = state_reg.sync2[i];
      if (i < sio_pkg::HOST_IN_COUNT) begin
        // Host value overrides the pin only where its mask bit is set
        if (state_reg.host_mask[sio_pkg::HOST_IN_LSB + i]) begin
          cn1_eff[i] = state_reg.host_val[sio_pkg::HOST_IN_LSB + i];
        end
      end
      cn1_eff[i] = cn1_eff[i] ^ input_invert_param_in[i];
      fn = input_function_param_in[i*sio_pkg::FN_WIDTH +: sio_pkg::FN_WIDTH];
      if (cn1_eff[i]) begin
        // Host-forwarded switches merge with wired ones
        if (fn == sio_pkg::FN_NEG_LIMIT) sw_neg = 1'b1;
        if (fn == sio_pkg::FN_POS_LIMIT) sw_pos = 1'b1;
        if (fn == sio_pkg::FN_HOME) sw_home = 1'b1;
        if (fn == sio_pkg::FN_PROBE_ONE) probe_one = 1'b1;
        if (fn == sio_pkg::FN_PROBE_TWO) probe_two = 1'b1;
      end
    end
    dig_in = 32'h00000000;
    dig_in[sio_pkg::DIG_NEG_LIM_BIT] = sw_neg;
    dig_in[sio_pkg::DIG_POS_LIM_BIT] = sw_pos;
    dig_in[sio_pkg::DIG_HOME_BIT] = sw_home;
    dig_in[sio_pkg::DIG_CN1_LSB +: sio_pkg::CN1_COUNT] = cn1_eff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Torque magnitude, stall test and capping
  always_comb begin
    cmd_ext = 17'(torque_cmd_in);
    pos_cap = $signed({1'b0, state_reg.pos_lim});
    neg_cap = -$signed({1'b0, state_reg.neg_lim});
    tq_abs = torque_feedback_in[15] ? 17'(-cmd_abs_src(torque_feedback_in))
                                    : 17'(torque_feedback_in);
    stalled = tq_abs >= {1'b0, stall_torque_threshold_param_in};
    ms_tick = state_reg.ms_cnt == 16'(MS_CYCLES - 1);
  end

  function automatic logic signed [16:0] cmd_abs_src(
    input logic signed [15:0] v
  );
    cmd_abs_src = 17'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {encoder_external_input_in, home_switch_pin_in,
                        pos_limit_pin_in, neg_limit_pin_in,
                        encoder_index_mark_in, digital_input_connector_in};
    state_next.sync2 = state_reg.sync1;
    state_next.index_prev = index_lvl;
    wr_ok = 1'b0;

    // Torque cap is applied to every command, homing or not
    if (cmd_ext > pos_cap) begin
      state_next.torque_cmd = 16'(pos_cap);
    end else if (cmd_ext < neg_cap) begin
      state_next.torque_cmd = 16'(neg_cap);
    end else begin
      state_next.torque_cmd = torque_cmd_in;
    end

    // Homing
    state_next.ms_cnt = 16'h0000;
    state_next.blk_cnt = 16'h0000;
    case (state_reg.hm)
      sio_pkg::SIO_HM_IDLE, sio_pkg::SIO_HM_DONE: begin
        if (homing_start_in) begin
          state_next.done = 1'b0;
          state_next.hm_is_index =
            homing_method_in == sio_pkg::HM_NEG_STALL_INDEX;
          if (homing_method_in == sio_pkg::HM_POS_STALL_HERE) begin
            state_next.dir_pos = 1'b1;
            state_next.hm = sio_pkg::SIO_HM_STALL;
          end else if (homing_method_in == sio_pkg::HM_NEG_STALL_HERE ||
                       homing_method_in == sio_pkg::HM_NEG_STALL_INDEX) begin
            state_next.dir_neg = 1'b1;
            state_next.hm = sio_pkg::SIO_HM_STALL;
          end else if (!homing_method_in[7] && homing_method_in != 8'h00)
          begin
            // An active negative limit forces positive travel, else an active positive limit forces negative
            state_next.dir_pos = sw_neg | (~sw_pos & homing_pref_pos_in);
            state_next.dir_neg = ~(sw_neg | (~sw_pos & homing_pref_pos_in));
            state_next.hm = sio_pkg::SIO_HM_SWITCH;
          end
        end
      end
      sio_pkg::SIO_HM_STALL: begin
        if (stalled) begin
          state_next.ms_cnt = ms_tick ? 16'h0000 : state_reg.ms_cnt + 16'h0001;
          state_next.blk_cnt = state_reg.blk_cnt + {15'h0000, ms_tick};
          if (state_reg.blk_cnt >= blocking_time_param_in) begin
            if (state_reg.hm_is_index) begin
              state_next.dir_pos = ~state_reg.dir_pos;
              state_next.dir_neg = ~state_reg.dir_neg;
              state_next.hm = sio_pkg::SIO_HM_INDEX;
            end else begin
              state_next.home_pos = feedback_position_in;
              state_next.dir_pos = 1'b0;
              state_next.dir_neg = 1'b0;
              state_next.done = 1'b1;
              state_next.hm = sio_pkg::SIO_HM_DONE;
            end
          end
        end
      end
      sio_pkg::SIO_HM_INDEX: begin
        if (index_rise) begin
          state_next.home_pos = feedback_position_in;
          state_next.dir_pos = 1'b0;
          state_next.dir_neg = 1'b0;
          state_next.done = 1'b1;
          state_next.hm = sio_pkg::SIO_HM_DONE;
        end
      end
      sio_pkg::SIO_HM_SWITCH: begin
        // Later switch sequencing is handled outside this block
      end
      default: begin
        state_next.hm = sio_pkg::SIO_HM_IDLE;
      end
    endcase
    if (homing_stop_in) begin
      state_next.dir_pos = 1'b0;
      state_next.dir_neg = 1'b0;
      state_next.hm = sio_pkg::SIO_HM_IDLE;
    end

    // Object access: answer one cycle after each request
    state_next.ack = obj_req_in;
    state_next.abort = 1'b0;
    state_next.rdata = 32'h00000000;
    if (obj_req_in) begin
      case (obj_index_in)
        sio_pkg::IDX_PROBE_CTRL: begin
          state_next.rdata = {16'h0000, state_reg.probe_ctrl};
          wr_ok = 1'b1;
          if (obj_write_in) begin
            state_next.probe_ctrl = obj_wdata_in[15:0];
          end
        end
        sio_pkg::IDX_PROBE_STAT: begin
          state_next.rdata = {16'h0000, probe_status};
        end
        sio_pkg::IDX_P1_RISE: state_next.rdata = p1_rise;
        sio_pkg::IDX_P1_FALL: state_next.rdata = p1_fall;
        sio_pkg::IDX_P2_RISE: state_next.rdata = p2_rise;
        sio_pkg::IDX_P2_FALL: state_next.rdata = p2_fall;
        sio_pkg::IDX_POS_TQ: begin
          state_next.rdata = {16'h0000, state_reg.pos_lim};
          wr_ok = obj_wdata_in <= {16'h0000, sio_pkg::TQ_LIMIT_MAX};
          if (obj_write_in && wr_ok) begin
            state_next.pos_lim = obj_wdata_in[15:0];
          end
        end
        sio_pkg::IDX_NEG_TQ: begin
          state_next.rdata = {16'h0000, state_reg.neg_lim};
          wr_ok = obj_wdata_in <= {16'h0000, sio_pkg::TQ_LIMIT_MAX};
          if (obj_write_in && wr_ok) begin
            state_next.neg_lim = obj_wdata_in[15:0];
          end
        end
        sio_pkg::IDX_DIG_IN: state_next.rdata = dig_in;
        sio_pkg::IDX_HOST_OUT: begin
          if (obj_subindex_in == sio_pkg::SUB_HOST_VAL) begin
            state_next.rdata = state_reg.host_val;
            wr_ok = 1'b1;
            if (obj_write_in) state_next.host_val = obj_wdata_in;
          end else if (obj_subindex_in == sio_pkg::SUB_HOST_MASK) begin
            state_next.rdata = state_reg.host_mask;
            wr_ok = 1'b1;
            if (obj_write_in) state_next.host_mask = obj_wdata_in;
          end else if (obj_subindex_in == sio_pkg::SUB_ZERO) begin
            state_next.rdata = sio_pkg::HOST_OUT_COUNT;
          end else begin
            state_next.abort = 1'b1;
          end
        end
        default: state_next.abort = 1'b1;
      endcase
      // Writes to read-only or out-of-range objects are refused
      if (obj_write_in && !wr_ok) begin
        state_next.abort = 1'b1;
      end
      if (obj_write_in || state_next.abort) begin
        state_next.rdata = 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
      state_reg.hm <= sio_pkg::SIO_HM_IDLE;
      state_reg.probe_ctrl <= sio_pkg::PROBE_CTRL_RESET;
      state_reg.pos_lim <= sio_pkg::TQ_LIMIT_RESET;
      state_reg.neg_lim <= sio_pkg::TQ_LIMIT_RESET;
      state_reg.host_val <= sio_pkg::HOST_OUT_RESET;
      state_reg.host_mask <= sio_pkg::HOST_OUT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign obj_ack_out = state_reg.ack;
  assign obj_abort_out = state_reg.abort;
  assign obj_rdata_out = state_reg.rdata;
  assign drive_pos_out = state_reg.dir_pos;
  assign drive_neg_out = state_reg.dir_neg;
  assign homing_done_out = state_reg.done;
  assign home_position_out = state_reg.home_pos;
  assign torque_cmd_out = state_reg.torque_cmd;
  assign pos_torque_limit_out = state_reg.pos_lim;
  assign neg_torque_limit_out = state_reg.neg_lim;

endmodule // sio_servo_io

// ### dv/sio_servo_io_properties.sv
// Concurrent checks on object access, torque caps and homing outputs.
// Sees only the top module's ports; bound from the bench top file.
module sio_servo_io_properties (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic obj_req_in,
  input wire logic obj_write_in,
  input wire logic [15:0] obj_index_in,
  input wire logic [31:0] obj_wdata_in,
  input wire logic obj_ack_out,
  input wire logic obj_abort_out,
  input wire logic [31:0] obj_rdata_out,
  input wire logic signed [15:0] torque_cmd_out,
  input wire logic [15:0] pos_torque_limit_out,
  input wire logic [15:0] neg_torque_limit_out,
  input wire logic drive_pos_out,
  input wire logic drive_neg_out,
  input wire logic homing_done_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic wr;
  logic rd;
  assign wr = obj_req_in && obj_write_in;
  assign rd = obj_req_in && !obj_write_in;
  ////////////////////////////////////////////////////////////////////////////
  req_gets_ack_a: assert property (obj_req_in |=> obj_ack_out)
    else $error("request without acknowledge");
  idle_no_ack_a: assert property (!obj_req_in |=> !obj_ack_out)
    else $error("acknowledge without request");
  tq_write_a: assert property (wr && obj_index_in == 16'h60E0 &&
    obj_wdata_in <= 32'h00000BB8 |=>
    {16'h0000, pos_torque_limit_out} == $past(obj_wdata_in))
    else $error("positive limit not written");
  tq_refuse_a: assert property (wr && obj_index_in == 16'h60E1 &&
    obj_wdata_in > 32'h00000BB8 |=>
    obj_abort_out && $stable(neg_torque_limit_out))
    else $error("oversize negative limit accepted");
  ro_refuse_a: assert property (wr && obj_index_in inside
    {[16'h60B9:16'h60BD], 16'h60FD} |=> obj_abort_out)
    else $error("write to read-only object accepted");
  tq_read_a: assert property (rd && obj_index_in == 16'h60E0 |=>
    !obj_abort_out && obj_rdata_out == {16'h0000, $past(pos_torque_limit_out)})
    else $error("positive limit read wrong");
  pos_cap_a: assert property ($stable(pos_torque_limit_out) &&
    torque_cmd_out > 0 |-> torque_cmd_out <= $signed({1'b0, pos_torque_limit_out}))
    else $error("positive torque above limit");
  neg_cap_a: assert property ($stable(neg_torque_limit_out) &&
    torque_cmd_out < 0 |-> torque_cmd_out >= -$signed({1'b0, neg_torque_limit_out}))
    else $error("negative torque beyond limit");
  dig_reserved_a: assert property (rd && obj_index_in == 16'h60FD |=>
    obj_rdata_out[31:24] == 8'h00 && obj_rdata_out[15:3] == 13'h0000)
    else $error("reserved input bits set");
  home_halt_a: assert property ($rose(homing_done_out) |->
    !drive_pos_out && !drive_neg_out)
    else $error("motion continues after homing");
  cover property (wr && obj_index_in == 16'h60E0);
  cover property ($rose(homing_done_out));
  cover property (obj_abort_out);
endmodule // sio_servo_io_properties

// ### dv/sio_host_model.sv
// Host controller model: one object request per call, answer collected.
// Assumes the block acknowledges at the edge after the request.
module sio_host_model (
  input wire logic ref_clk_in,
  input wire logic obj_ack_in,
  input wire logic obj_abort_in,
  input wire logic [31:0] obj_rdata_in,
  output logic obj_req_out = 1'b0,
  output logic obj_write_out = 1'b0,
  output logic [15:0] obj_index_out = 16'h0000,
  output logic [7:0] obj_subindex_out = 8'h00,
  output logic [31:0] obj_wdata_out = 32'h00000000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Switch states forwarded by the host travel as plain object data
  task automatic xfer(input logic w, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] d,
      output logic [31:0] rd, output logic ab);
    @(posedge ref_clk_in);
    obj_req_out <= 1'b1;
    obj_write_out <= w;
    obj_index_out <= idx;
    obj_subindex_out <= sub;
    obj_wdata_out <= d;
    @(posedge ref_clk_in);
    obj_req_out <= 1'b0;
    obj_wdata_out <= ~d; // Released data must not look valid
    @(posedge ref_clk_in);
    rd = obj_ack_in ? obj_rdata_in : {32{1'bx}};
    ab = obj_ack_in ? obj_abort_in : 1'bx;
  endtask
endmodule // sio_host_model

// ### dv/sio_servo_io_test.sv
// Bench top: object access tests, probe latching and stall homing.
// Assumes the host model paces requests; MS_CYCLES is cut to 10.
module sio_servo_io_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic obj_req_in, obj_write_in, obj_ack_out, obj_abort_out, ab;
  logic [15:0] obj_index_in, pos_torque_limit_out, neg_torque_limit_out;
  logic [7:0] obj_subindex_in;
  logic [31:0] obj_wdata_in, obj_rdata_out, home_position_out, rd;
  logic [7:0] digital_input_connector_in = 8'h00;
  logic neg_limit_pin_in = 1'b0, pos_limit_pin_in = 1'b0;
  logic home_switch_pin_in = 1'b0, encoder_index_mark_in = 1'b0;
  logic encoder_external_input_in = 1'b0, homing_start_in = 1'b0;
  logic homing_stop_in = 1'b0, homing_pref_pos_in = 1'b0;
  logic [7:0] input_invert_param_in = 8'h00, homing_method_in = 8'h00;
  logic [23:0] input_function_param_in = 24'h000018;
  logic [15:0] stall_torque_threshold_param_in = 16'h0064;
  logic [15:0] blocking_time_param_in = 16'h0001;
  logic signed [15:0] torque_feedback_in = 16'sh0000;
  logic signed [15:0] torque_cmd_in = 16'sh0000, torque_cmd_out;
  logic signed [31:0] feedback_position_in = 32'sh00000000;
  logic drive_pos_out, drive_neg_out, homing_done_out;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  sio_servo_io #(.MS_CYCLES(10)) u_sio_servo_io (.*);
  sio_host_model u_host (.ref_clk_in(ref_clk_in), .obj_ack_in(obj_ack_out),
    .obj_abort_in(obj_abort_out), .obj_rdata_in(obj_rdata_out),
    .obj_req_out(obj_req_in), .obj_write_out(obj_write_in),
    .obj_index_out(obj_index_in), .obj_subindex_out(obj_subindex_in),
    .obj_wdata_out(obj_wdata_in));
  always #12.5 ref_clk_in = ~ref_clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    u_host.xfer(1'b0, i, s, 32'h00000000, rd, ab);
    chk($sformatf("object %h.%h", i, s), e, rd);
  endtask
  task automatic wrc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
      input logic e);
    u_host.xfer(1'b1, i, s, d, rd, ab);
    chk($sformatf("abort %h", i), {31'h0, e}, {31'h0, ab});
  endtask
  task automatic trig(input logic idx, input logic [31:0] pos);
    @(posedge ref_clk_in);
    feedback_position_in <= pos;
    encoder_index_mark_in <= idx;
    encoder_external_input_in <= !idx;
    repeat (3) @(posedge ref_clk_in);
    encoder_index_mark_in <= 1'b0;
    encoder_external_input_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
  // Stall is faked by a torque above threshold; the index ends method -3
  task automatic home(input logic [7:0] m, input logic dir);
    @(posedge ref_clk_in);
    homing_method_in <= m;
    homing_stop_in <= 1'b0;
    homing_start_in <= 1'b1;
    feedback_position_in <= {24'h000000, m};
    @(posedge ref_clk_in);
    homing_start_in <= 1'b0;
    torque_feedback_in <= dir ? 16'sh00C8 : -16'sh00C8;
    @(posedge ref_clk_in);
    chk("direction", {30'h0, dir, !dir}, {30'h0, drive_pos_out, drive_neg_out});
    for (int i = 0; i < 60 && !homing_done_out && !(m == 8'hFD && drive_pos_out); i++)
      @(posedge ref_clk_in);
    if (m == 8'hFD) begin
      chk("reverse", 32'h00000001, {31'h0, drive_pos_out});
      trig(1'b1, 32'h0000ABCD);
      for (int i = 0; i < 60 && !homing_done_out; i++)
        @(posedge ref_clk_in);
    end
    chk("done", 32'h00000001, {31'h0, homing_done_out});
    chk("home", feedback_position_in, home_position_out);
    torque_feedback_in <= 16'sh0000;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    rdc(16'h60E0, 8'h00, 32'h00000BB8);
    rdc(16'h60E1, 8'h00, 32'h00000BB8);
    rdc(16'h60FE, 8'h02, 32'h00000000);
    wrc(16'h60E0, 8'h00, 32'h00000064, 1'b0);
    wrc(16'h60E1, 8'h00, 32'h00000BB9, 1'b1);
    wrc(16'h60E1, 8'h00, 32'h000000C8, 1'b0);
    wrc(16'h1234, 8'h00, 32'h00000000, 1'b1);
    @(posedge ref_clk_in);
    torque_cmd_in <= 16'sh01F4;
    repeat (3) @(posedge ref_clk_in);
    chk("torque cap", 32'h00000064, {16'h0000, torque_cmd_out});
    torque_cmd_in <= -16'sh01F4;
    repeat (3) @(posedge ref_clk_in);
    chk("torque cap", 32'h0000FF38, {16'h0000, torque_cmd_out});
    $display("test torque limits done");
    neg_limit_pin_in <= 1'b1;
    digital_input_connector_in <= 8'hA4;
    repeat (4) @(posedge ref_clk_in);
    rdc(16'h60FD, 8'h00, 32'h00A40001);
    wrc(16'h60FE, 8'h01, 32'h30000000, 1'b0);
    rdc(16'h60FD, 8'h00, 32'h00A40001);
    wrc(16'h60FE, 8'h02, 32'h30000000, 1'b0);
    repeat (4) @(posedge ref_clk_in);
    rdc(16'h60FD, 8'h00, 32'h00A70005);
    homing_method_in <= 8'h01;
    homing_start_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    chk("start", 32'h2, {30'h0, drive_pos_out, drive_neg_out});
    homing_stop_in <= 1'b1;
    wrc(16'h60FE, 8'h02, 32'h00000000, 1'b0);
    neg_limit_pin_in <= 1'b0;
    $display("test digital inputs done");
    wrc(16'h60B8, 8'h00, 32'h00000013, 1'b0);
    for (int i = 1; i <= 4; i++) begin
      trig(1'b0, 32'(i));
      rdc(16'h60B9, 8'h00, 32'h00000003 | 32'((i % 4) << 6));
      rdc(16'h60BA, 8'h00, 32'(i));
    end
    wrc(16'h60B8, 8'h00, 32'h00000000, 1'b0);
    wrc(16'h60B8, 8'h00, 32'h00003511, 1'b0);
    trig(1'b0, 32'h00000100);
    trig(1'b0, 32'h00000200);
    trig(1'b1, 32'hFFFFFF00);
    rdc(16'h60B9, 8'h00, 32'h00000703);
    rdc(16'h60BA, 8'h00, 32'h00000100);
    rdc(16'h60BC, 8'h00, 32'hFFFFFF00);
    rdc(16'h60BD, 8'h00, 32'hFFFFFF00);
    wrc(16'h60BA, 8'h00, 32'h00000000, 1'b1);
    $display("test probes done");
    home(8'hFF, 1'b0);
    home(8'hFE, 1'b1);
    home(8'hFD, 1'b0);
    $display("test homing done");
    end_of_test;
  end
endmodule // sio_servo_io_test

bind sio_servo_io sio_servo_io_properties u_sio_servo_io_properties (.*);
